// File: pkg/dcsr_params.svh
// constants for the dual channel serdes register bank
// What this block does
// - channel A byte, first bit at bit 0
// - channel B byte, same ascending order
// - B mask bit set for valid data bit
// - B mask read-only, writes ignored
// - B all-valid flag means all bits valid
// - A all-valid flag means all bits valid
// - enable bit 3 gates underflow interrupt
// - enable bit 2 gates overflow interrupt
// - enable bit 1 gates done interrupt
// - enable bit 0 gates empty interrupt
// - status flags set regardless of enables
// - full A set on transfer into register
// - overflow on unread load, underflow on empty read
`ifndef DCSR_PARAMS_SVH
`define DCSR_PARAMS_SVH
`define DCSR_OFS_RX_STAT   6'h08
`define DCSR_OFS_A_BYTE    6'h09
`define DCSR_OFS_A_MASK    6'h0A
`define DCSR_OFS_B_BYTE    6'h0B
`define DCSR_OFS_B_MASK    6'h0C
`define DCSR_OFS_TX_EN     6'h0D
`define DCSR_OFS_TX_STAT   6'h0E
`define DCSR_RST_BYTE      8'h00
`define DCSR_TX_EN_MASK    8'h0F
`define DCSR_BIT_UNDER     3
`define DCSR_BIT_OVER      2
`define DCSR_BIT_DONE      1
`define DCSR_BIT_EMPTY     0
`endif

// File: pkg/dcsr_pkg.sv
// types for the dual channel serdes register bank
package dcsr_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] mask;
    logic       full;
    logic       flow;
    logic       eof;
    logic       all_valid;
  } dcsr_chan_t;
  typedef enum logic [1:0] {
    DCSR_IDLE = 2'b00,
    DCSR_READ = 2'b01
  } dcsr_rd_state_t;
endpackage

// File: core/dcsr_chan.sv
// one receive channel: data byte, valid mask and flags
`timescale 1ns/1ps
`include "dcsr_params.svh"
module dcsr_chan
  import dcsr_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            load,
  input  wire logic            load_eof,
  input  wire logic [7:0]      load_data,
  input  wire logic [7:0]      load_mask,
  input  wire logic            rd_byte,
  input  wire logic            rd_stat,
  output dcsr_pkg::dcsr_chan_t st
);
  import dcsr_pkg::*;

  typedef struct packed {
    dcsr_chan_t ch;
  } dcsr_chan_state_t;

  dcsr_chan_state_t st_reg;
  dcsr_chan_state_t st_next;

  // ****************
  // next state
  // ****************
  always_comb
  begin
    st_next = st_reg;
    // status read clears the sticky events; a new event below wins
    if (rd_stat)
    begin
      st_next.ch.flow = 1'b0;
      st_next.ch.eof  = 1'b0;
    end
    if (rd_byte)
    begin
      if (!st_reg.ch.full)
        st_next.ch.flow = 1'b1;
      st_next.ch.full = 1'b0;
    end
    if (load_eof)
      st_next.ch.eof = 1'b1;
    if (load)
    begin
      if (st_reg.ch.full && !rd_byte)
        st_next.ch.flow = 1'b1;
      st_next.ch.full      = 1'b1;
      st_next.ch.data      = load_data;
      st_next.ch.mask      = load_mask;
      st_next.ch.all_valid = &load_mask;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign st = st_reg.ch;

  // ****************
  // checks
  // ****************
  load_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    load |=> st.full)
    else $error("full not set after load");
  mask_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    load |=> st.mask == $past(load_mask))
    else $error("mask not loaded");
  all_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
    st.all_valid |-> st.mask == 8'hFF)
    else $error("all valid with partial mask");
  over_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (load && st.full && !rd_byte) |=> st.flow)
    else $error("overflow missed");
  under_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_byte && !st.full) |=> st.flow)
    else $error("underflow missed");
  load_cov: cover property (@(posedge clk) disable iff (!rst_n)
    load ##[1:4] rd_byte);
endmodule

// File: core/dcsr_top.sv
// serdes register bank: receive channels A/B and transmit irq enable
`timescale 1ns/1ps
`include "dcsr_params.svh"
module dcsr_top
  import dcsr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port from the serial peripheral decoder
  input  wire logic [5:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // receive correlators, bit 0 is the first bit over the air
  input  wire logic       a_load,
  input  wire logic       a_eof,
  input  wire logic [7:0] a_data,
  input  wire logic [7:0] a_mask,
  input  wire logic       b_load,
  input  wire logic       b_eof,
  input  wire logic [7:0] b_data,
  input  wire logic [7:0] b_mask,
  // transmit serdes events, one-cycle pulses
  input  wire logic       tx_underflow,
  input  wire logic       tx_overflow,
  input  wire logic       tx_done,
  input  wire logic       tx_empty_set,
  input  wire logic       tx_empty_clr,
  output logic            irq
);
  import dcsr_pkg::*;

  // ****************
  // state and decode
  // ****************
  typedef struct packed {
    logic [7:0]     tx_en;
    logic [3:0]     tx_stat;
    logic [7:0]     rdata;
    dcsr_rd_state_t rd_state;
  } dcsr_top_state_t;

  dcsr_top_state_t s_reg;
  dcsr_top_state_t s_next;
  dcsr_chan_t      ch_a;
  dcsr_chan_t      ch_b;
  logic            rd_stb;
  logic [3:0]      tx_ev;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a == o);
  endfunction

  // read strobe fires once per read request
  assign rd_stb = reg_rd && (s_reg.rd_state == DCSR_IDLE);

  // ****************
  // receive channels
  // ****************
  dcsr_chan u_chan_a (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (a_load),
    .load_eof (a_eof),
    .load_data(a_data),
    .load_mask(a_mask),
    .rd_byte  (rd_stb && hit(reg_addr, `DCSR_OFS_A_BYTE)),
    .rd_stat  (rd_stb && hit(reg_addr, `DCSR_OFS_RX_STAT)),
    .st       (ch_a)
  );

  dcsr_chan u_chan_b (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (b_load),
    .load_eof (b_eof),
    .load_data(b_data),
    .load_mask(b_mask),
    .rd_byte  (rd_stb && hit(reg_addr, `DCSR_OFS_B_BYTE)),
    .rd_stat  (rd_stb && hit(reg_addr, `DCSR_OFS_RX_STAT)),
    .st       (ch_b)
  );

  // ****************
  // transmit status and read mux
  // ****************
  assign tx_ev = {tx_underflow, tx_overflow, tx_done, tx_empty_set};

  always_comb
  begin
    s_next = s_reg;
    s_next.rd_state = reg_rd ? DCSR_READ : DCSR_IDLE;
    // reserved enable bits are not stored, so they read back as zero
    if (reg_wr && hit(reg_addr, `DCSR_OFS_TX_EN))
      s_next.tx_en = reg_wdata & `DCSR_TX_EN_MASK;
    // status read clears underflow/overflow/done; new events win
    if (rd_stb && hit(reg_addr, `DCSR_OFS_TX_STAT))
      s_next.tx_stat[3:1] = 3'h0;
    if (tx_empty_clr)
      s_next.tx_stat[`DCSR_BIT_EMPTY] = 1'b0;
    s_next.tx_stat = s_next.tx_stat | tx_ev;
    if (rd_stb)
    begin
      case (reg_addr)
        `DCSR_OFS_RX_STAT:
          s_next.rdata = {ch_b.all_valid, ch_b.flow, ch_b.eof, ch_b.full,
                          ch_a.all_valid, ch_a.flow, ch_a.eof, ch_a.full};
        `DCSR_OFS_A_BYTE: s_next.rdata = ch_a.data;
        `DCSR_OFS_A_MASK: s_next.rdata = ch_a.mask;
        `DCSR_OFS_B_BYTE: s_next.rdata = ch_b.data;
        `DCSR_OFS_B_MASK: s_next.rdata = ch_b.mask;
        `DCSR_OFS_TX_EN:  s_next.rdata = s_reg.tx_en;
        `DCSR_OFS_TX_STAT: s_next.rdata = {4'h0, s_reg.tx_stat};
        default:          s_next.rdata = `DCSR_RST_BYTE;
      endcase
    end
  end

  // ****************
  // registers and outputs
  // ****************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_reg.tx_en    <= `DCSR_RST_BYTE;
      s_reg.tx_stat  <= 4'h0;
      s_reg.rdata    <= `DCSR_RST_BYTE;
      s_reg.rd_state <= DCSR_IDLE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  // level request; it drops once the flag or its enable bit is cleared
  assign irq = |(s_reg.tx_stat & s_reg.tx_en[3:0]);

  // ****************
  // checks
  // ****************
  en_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.tx_en[7:4] == 4'h0)
    else $error("reserved enable bits stored");
  under_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.tx_stat[3] && s_reg.tx_en[3]) |-> irq)
    else $error("underflow irq missing");
  over_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.tx_stat[2] && s_reg.tx_en[2]) |-> irq)
    else $error("overflow irq missing");
  done_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.tx_stat[1] && s_reg.tx_en[1]) |-> irq)
    else $error("done irq missing");
  empty_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.tx_stat[0] && s_reg.tx_en[0]) |-> irq)
    else $error("empty irq missing");
  poll_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    tx_overflow |=> s_reg.tx_stat[2])
    else $error("flag not set while masked");
  irq_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    irq |-> (s_reg.tx_stat & s_reg.tx_en[3:0]) != 4'h0)
    else $error("spurious irq");
  irq_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.tx_en[3:0] == 4'h0) |-> !irq)
    else $error("irq with all enables off");
  mask_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && hit(reg_addr, `DCSR_OFS_B_MASK) && !b_load)
      |=> $stable(ch_b.mask))
    else $error("write changed mask b");

  // read mux returns the register as it stood at the read edge
  rd_a_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_stb && hit(reg_addr, `DCSR_OFS_A_BYTE))
      |=> reg_rdata == $past(ch_a.data))
    else $error("channel a byte not returned");
  rd_b_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_stb && hit(reg_addr, `DCSR_OFS_B_BYTE))
      |=> reg_rdata == $past(ch_b.data))
    else $error("channel b byte not returned");
  rd_b_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_stb && hit(reg_addr, `DCSR_OFS_B_MASK))
      |=> reg_rdata == $past(ch_b.mask))
    else $error("channel b mask not returned");
  rd_a_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_stb && hit(reg_addr, `DCSR_OFS_A_MASK))
      |=> reg_rdata == $past(ch_a.mask))
    else $error("channel a mask not returned");
  rd_rx_stat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_stb && hit(reg_addr, `DCSR_OFS_RX_STAT))
      |=> (reg_rdata[7] == $past(ch_b.all_valid))
        && (reg_rdata[3] == $past(ch_a.all_valid)))
    else $error("all valid flags not returned");
  en_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && hit(reg_addr, `DCSR_OFS_TX_EN))
      |=> s_reg.tx_en[3:0] == $past(reg_wdata[3:0]))
    else $error("enable write lost");

  // transmit flags: a new event beats a clear in the same cycle
  stat_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_stb && hit(reg_addr, `DCSR_OFS_TX_STAT) && !tx_done)
      |=> !s_reg.tx_stat[`DCSR_BIT_DONE])
    else $error("done flag not cleared by status read");
  empty_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    tx_empty_set |=> s_reg.tx_stat[`DCSR_BIT_EMPTY])
    else $error("empty flag not set");
  empty_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_empty_clr && !tx_empty_set)
      |=> !s_reg.tx_stat[`DCSR_BIT_EMPTY])
    else $error("empty flag not cleared");

  // ****************
  // covers
  // ****************
  irq_cov: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(irq));
  masked_ev_cov: cover property (@(posedge clk) disable iff (!rst_n)
    tx_overflow && !s_reg.tx_en[`DCSR_BIT_OVER]);
  rd_a_cov: cover property (@(posedge clk) disable iff (!rst_n)
    rd_stb && hit(reg_addr, `DCSR_OFS_A_BYTE));
  wr_en_cov: cover property (@(posedge clk) disable iff (!rst_n)
    reg_wr && hit(reg_addr, `DCSR_OFS_TX_EN));
endmodule

// File: tb/dcsr_host.sv
// host model: register reads and writes on the serial port side
`timescale 1ns/1ps
module dcsr_host
(
  input  wire logic       clk,
  output logic      [5:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr  = 6'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // one access; rd drops for a cycle so the next read is seen again
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = w ? (d & 8'h0F) : d;
    reg_wr    = w;
    reg_rd    = !w;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    @(posedge clk);
    #1;
    q = reg_rdata;
  endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the serdes register bank
`timescale 1ns/1ps
module testbench;
  import dcsr_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [5:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        a_load, a_eof, b_load, b_eof;
  logic [7:0]  a_data, a_mask, b_data, b_mask;
  logic        tx_underflow, tx_overflow, tx_done;
  logic        tx_empty_set, tx_empty_clr, irq;
  int          fails;
  int          checks;
  logic [31:0] seed;
  logic [7:0]  q, da, ma, db, mb, en;

  dcsr_top  dcsr_top_i (.*);
  dcsr_host dcsr_host_i (.*);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    dcsr_host_i.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    dcsr_host_i.xfer(1'b1, a, d, q);
  endtask

  // correlator side; released data and mask lines show the inverse of the last value, strobes drop to zero
  task automatic ld(input logic la, input logic lb, input logic e);
    @(posedge clk);
    #1;
    {a_load, b_load, a_eof, b_eof} = {la, lb, e, e};
    {a_data, a_mask, b_data, b_mask} = {da, ma, db, mb};
    @(posedge clk);
    #1;
    {a_load, b_load, a_eof, b_eof} = 4'h0;
    {a_data, a_mask, b_data, b_mask} = ~{da, ma, db, mb};
  endtask

  task automatic ev(input logic [4:0] p);
    @(posedge clk);
    #1;
    {tx_empty_clr, tx_underflow, tx_overflow, tx_done, tx_empty_set} = p;
    @(posedge clk);
    #1;
    {tx_empty_clr, tx_underflow, tx_overflow, tx_done, tx_empty_set} = 5'h00;
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    stop_test();
  end

  // ****************
  // scenarios
  // ****************
  initial
  begin
    {rst_n, a_load, b_load, a_eof, b_eof} = 5'h00;
    {a_data, a_mask, b_data, b_mask} = 32'h0;
    {tx_empty_clr, tx_underflow, tx_overflow, tx_done, tx_empty_set} = 5'h00;
    fails = 0;
    checks = 0;
    seed = 32'h0F7AAA96;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int i = 9; i < 15; i++)
      rd(i[5:0], 8'h00);
    // the empty byte reads above were underflows on both channels
    rd(6'h08, 8'h44);
    rd(6'h3F, 8'h00);
    $display("test reset done");
    en = rnd();
    wr(6'h0D, en);
    wr(6'h0C, 8'hFF);
    rd(6'h0D, en & 8'h0F);
    rd(6'h0C, 8'h00);
    $display("test access done");
    for (int k = 0; k < 2; k++)
    begin
      da = rnd();
      ma = rnd();
      db = rnd();
      mb = k ? rnd() : 8'hFF;
      ld(1'b1, 1'b1, 1'b1);
      rd(6'h08, {&mb, 3'b011, &ma, 3'b011});
      rd(6'h0A, ma);
      rd(6'h09, da);
      rd(6'h0C, mb);
      rd(6'h0B, db);
      // reading the emptied byte is an underflow
      dcsr_host_i.xfer(1'b0, 6'h09, 8'h00, q);
      ld(1'b0, 1'b1, 1'b0);
      ld(1'b0, 1'b1, 1'b0);
      rd(6'h08, {&mb, 3'b101, &ma, 3'b100});
      rd(6'h0B, db);
    end
    $display("test receive done");
    for (int i = 0; i < 4; i++)
    begin
      en = rnd() & 8'h0F;
      en[i] = (i < 2);
      wr(6'h0D, en);
      ev(5'h01 << i);
      chk("irq", {7'h0, en[i]}, {7'h0, irq});
      rd(6'h0E, 8'h01 << i);
      ev(5'h10);
      chk("irq idle", 8'h00, {7'h0, irq});
    end
    $display("test transmit irq done");
    stop_test();
  end
endmodule
